// >>> test/two_wire_register_slave_tb.sv
// self-checking bench joining the two-wire master and slave
`timescale 1ns/1ns
module two_wire_register_slave_tb;
  import tws_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic alt_address_enable = 1'b0;
  logic alt_address_select = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_use_addr = 1'b0;
  logic [6:0] cmd_dev = 7'h00;
  logic [15:0] cmd_reg = 16'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic cmd_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_nack;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata = 8'h00;
  logic [15:0] programmable_bus_address;
  logic [15:0] wr_addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] b;
  int wr_count = 0;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int wc;
  logic [7:0] rd_q[$];
  always #10 core_clk = ~core_clk;
  tws_bus_if bus();
  assign bus.scl = bus.scl_oe ? 1'b0 : 1'b1;
  assign bus.bus_data_line = (bus.sda_m_oe | bus.sda_s_oe) ? 1'b0 : 1'b1;
  tws_slave i_tws_slave (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus.slave),
    .alt_address_enable(alt_address_enable), .alt_address_select(alt_address_select),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .programmable_bus_address(programmable_bus_address));
  tws_master i_tws_master (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus.master),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_use_addr(cmd_use_addr),
    .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
  tws_bus_properties i_tws_bus_properties (.core_clk(core_clk), .sys_rst(sys_rst),
    .scl(bus.scl), .bus_data_line(bus.bus_data_line), .scl_o(bus.scl_o),
    .scl_oe(bus.scl_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
    .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe));
  // =====================================
  // register side model and monitors
  function automatic logic [7:0] rd_model(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction : rd_model
  always @(posedge core_clk) begin
    if (reg_re) reg_rdata <= rd_model(reg_addr);
    if (reg_we) begin
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
      wr_count <= wr_count + 1;
    end
    if (rsp_valid) rd_q.push_back(rsp_data);
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  // =====================================
  // tasks
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  task automatic pop_rd(output logic [7:0] v);
    v = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
  endtask : pop_rd
  task automatic send(input logic rd, input logic ua, input logic [6:0] dev,
    input logic [15:0] ra, input logic [7:0] wd, input logic [7:0] len);
    int t;
    t = 0;
    do begin
      @(posedge core_clk);
      #2;
      t++;
    end while (cmd_ready !== 1'b1 && t < 20000);
    cmd_read = rd;
    cmd_use_addr = ua;
    cmd_dev = dev;
    cmd_reg = ra;
    cmd_wdata = wd;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #2;
    cmd_valid = 1'b0;
    t = 0;
    do begin
      @(posedge core_clk);
      #2;
      t++;
    end while (cmd_ready !== 1'b1 && t < 20000);
  endtask : send
  // =====================================
  // tests
  initial begin
    repeat (16) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    chk_val(programmable_bus_address, PROG_ADDR_RESET);
    chk_val(reg_addr, PTR_RESET);
    send(DIR_WRITE, 1'b0, DEF_ADDR, 16'h1234, 8'ha5, 8'h01);
    chk_flag(rsp_nack, 1'b0);
    chk_val(wr_addr, 16'h1234);
    chk_val({8'h00, wr_data}, 16'h00a5);
    chk_val(reg_addr, 16'h1235);
    $display("test write done");
    send(DIR_READ, 1'b1, DEF_ADDR, 16'h12ff, 8'h00, 8'h02);
    chk_flag(rsp_nack, 1'b0);
    pop_rd(b);
    chk_val({8'h00, b}, {8'h00, rd_model(16'h12ff)});
    pop_rd(b);
    chk_val({8'h00, b}, {8'h00, rd_model(16'h1300)});
    $display("test random read done");
    send(DIR_READ, 1'b0, DEF_ADDR, 16'h0000, 8'h00, 8'h01);
    pop_rd(b);
    chk_val({8'h00, b}, {8'h00, rd_model(16'h1301)});
    chk_val(reg_addr, 16'h1302);
    $display("test current read done");
    wc = wr_count;
    send(DIR_WRITE, 1'b0, ALT_ADDR, 16'h0042, 8'h11, 8'h01);
    chk_flag(rsp_nack, 1'b1);
    chk_val(16'(wr_count), 16'(wc));
    $display("test foreign address done");
    alt_address_enable = 1'b1;
    alt_address_select = 1'b1;
    send(DIR_WRITE, 1'b0, ALT_ADDR, 16'hffff, 8'h77, 8'h01);
    chk_flag(rsp_nack, 1'b0);
    chk_val(wr_addr, 16'hffff);
    send(DIR_READ, 1'b0, DEF_ADDR, 16'h0000, 8'h00, 8'h01);
    chk_flag(rsp_nack, 1'b1);
    send(DIR_READ, 1'b0, ALT_ADDR, 16'h0000, 8'h00, 8'h01);
    pop_rd(b);
    chk_val({8'h00, b}, {8'h00, rd_model(16'h0000)});
    $display("test alternate address done");
    alt_address_enable = 1'b0;
    alt_address_select = 1'b0;
    send(DIR_WRITE, 1'b0, DEF_ADDR, PROG_ADDR_OFFSET, 8'h01, 8'h01);
    chk_flag(rsp_nack, 1'b0);
    chk_val(programmable_bus_address, 16'h0100);
    send(DIR_WRITE, 1'b0, DEF_ADDR, PROG_ADDR_OFFSET + 16'h0001, 8'h3c, 8'h01);
    chk_val(programmable_bus_address, 16'h013c);
    // enabled byte 0x3c carries seven-bit address 0x1e
    send(DIR_READ, 1'b0, 7'h1e, 16'h0000, 8'h00, 8'h01);
    chk_flag(rsp_nack, 1'b0);
    pop_rd(b);
    chk_val({8'h00, b}, {8'h00, rd_model(16'h31fe)});
    $display("test programmable address done");
    final_report();
  end
endmodule : two_wire_register_slave_tb

// >>> test/tws_bus_properties.sv
// wire-level checker for the two-wire master and slave pair
`timescale 1ns/1ns
module tws_bus_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic bus_data_line,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  // =====================================
  // sequences
  sequence s_stop;
    scl && $past(scl) && $rose(bus_data_line);
  endsequence
  sequence s_high8;
    sda_s_oe[*8];
  endsequence
  // =====================================
  // properties
  property p_rst_quiet;
    sys_rst |=> !sda_s_oe && !sda_m_oe && !scl_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus driven during reset");
  property p_s_open_drain;
    disable iff (sys_rst) sda_s_oe |-> !sda_s_o;
  endproperty
  a_s_open_drain: assert property (p_s_open_drain) else $error("slave drives data high");
  property p_m_open_drain;
    disable iff (sys_rst) sda_m_oe |-> !sda_m_o;
  endproperty
  a_m_open_drain: assert property (p_m_open_drain) else $error("master drives data high");
  property p_scl_od;
    disable iff (sys_rst) scl_oe |-> !scl_o;
  endproperty
  a_scl_od: assert property (p_scl_od) else $error("clock driven high");
  property p_s_rise_low;
    disable iff (sys_rst) $rose(sda_s_oe) |-> !scl;
  endproperty
  a_s_rise_low: assert property (p_s_rise_low) else $error("slave pulls data while clock high");
  property p_s_fall_low;
    disable iff (sys_rst) $fell(sda_s_oe) |-> !scl;
  endproperty
  a_s_fall_low: assert property (p_s_fall_low) else $error("slave releases while clock high");
  property p_no_clash;
    disable iff (sys_rst) !(sda_m_oe && sda_s_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_ack_in_clock;
    disable iff (sys_rst) $rose(sda_s_oe) |-> ##[1:100] $rose(scl);
  endproperty
  a_ack_in_clock: assert property (p_ack_in_clock) else $error("slave drive without clock");
  property p_hold_high;
    disable iff (sys_rst) sda_s_oe && $rose(scl) |-> s_high8;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("slave drive dropped in high");
  property p_quiet_stop;
    disable iff (sys_rst) s_stop |-> (!sda_s_oe)[*8];
  endproperty
  a_quiet_stop: assert property (p_quiet_stop) else $error("slave drives after stop");
endmodule : tws_bus_properties

// >>> verilog/tws_bus_if.sv
// interface carrying the clock and data lines between master and slave
`timescale 1ns/1ns
interface tws_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic bus_data_line;
  modport slave (
    input scl,
    input bus_data_line,
    output sda_s_o,
    output sda_s_oe
  );
  modport master (
    input scl,
    input bus_data_line,
    output scl_o,
    output scl_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface : tws_bus_if

// >>> verilog/tws_line_watch.sv
// edge and condition detector for the clock and data lines
`timescale 1ns/1ns
module tws_line_watch
  import tws_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_now
);
  logic scl_q;
  logic sda_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  // start and stop are data edges while the clock stays high
  assign start_seen = scl & scl_q & sda_q & ~sda;
  assign stop_seen = scl & scl_q & ~sda_q & sda;
  assign sda_now = sda_q;
endmodule : tws_line_watch

// >>> verilog/tws_master.sv
// host end: two-wire bus master issuing register transfers
`timescale 1ns/1ns
module tws_master
  import tws_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  tws_bus_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_use_addr,
  input wire logic [6:0] cmd_dev,
  input wire logic [15:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_nack
);
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} tws_mstate_e;
  tws_mstate_e state;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [7:0] sh;
  logic [3:0] bit_cnt;
  logic [2:0] step;
  logic rx_mode;
  logic [7:0] left;
  logic scl_low;
  logic sda_low;
  logic rd;
  logic ua;
  logic [6:0] dev;
  logic [15:0] rg;
  logic [7:0] wd;
  wire tick = (qcnt == QUARTER_CNT);
  wire sda_in = bus.bus_data_line;
  // step codes: 0 addr-w, 1 hi, 2 lo, 3 data, 4 restart, 5 addr-r, 6 read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= M_IDLE;
      qcnt <= 8'h00;
      phase <= 2'h0;
      sh <= 8'h00;
      bit_cnt <= 4'h0;
      step <= 3'h0;
      rx_mode <= 1'b0;
      left <= 8'h00;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rd <= 1'b0;
      ua <= 1'b0;
      dev <= 7'h00;
      rg <= 16'h0000;
      wd <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
      if (state == M_IDLE) begin
        if (cmd_valid & cmd_ready) begin
          cmd_ready <= 1'b0;
          rsp_nack <= 1'b0;
          rd <= cmd_read;
          ua <= cmd_use_addr;
          dev <= cmd_dev;
          rg <= cmd_reg;
          wd <= cmd_wdata;
          left <= cmd_len;
          step <= (cmd_read & ~cmd_use_addr) ? 3'h5 : 3'h0;
          state <= M_START;
          phase <= 2'h0;
        end
      end else if (tick) begin
        phase <= phase + 2'h1;
        unique case (state)
          M_START: begin
            // data falls while clock high, then clock falls
            if (phase == 2'h0) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h1) begin
              sda_low <= 1'b1;
            end else if (phase == 2'h2) begin
              scl_low <= 1'b1;
              sh <= (step == 3'h5) ? {dev, DIR_READ} : {dev, DIR_WRITE};
              rx_mode <= 1'b0;
              bit_cnt <= 4'h0;
              state <= M_BIT;
              phase <= 2'h0;
            end
          end
          M_BIT: begin
            if (phase == 2'h0) begin
              sda_low <= rx_mode ? 1'b0 : ~sh[7];
            end else if (phase == 2'h1) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h2) begin
              sh <= {sh[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else begin
              scl_low <= 1'b1;
              if (bit_cnt == BITS_PER_BYTE) begin
                // hand the data line over before the acknowledge
                sda_low <= 1'b0;
                state <= M_ACK;
              end
            end
          end
          M_ACK: begin
            if (phase == 2'h0) begin
              // ack every read byte but the last
              sda_low <= rx_mode & (left != 8'h01);
            end else if (phase == 2'h1) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h2) begin
              if (rx_mode) begin
                rsp_data <= sh;
                rsp_valid <= 1'b1;
              end else if (sda_in) begin
                rsp_nack <= 1'b1;
              end
            end else begin
              scl_low <= 1'b1;
              // free the line so a reading slave can take it at once
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              state <= M_BIT;
              if (rsp_nack) begin
                state <= M_STOP;
              end else if (rx_mode) begin
                left <= left - 8'h01;
                if (left == 8'h01) begin
                  state <= M_STOP;
                end
              end else begin
                unique case (step)
                  3'h0: begin
                    step <= 3'h1;
                    sh <= rg[15:8];
                  end
                  3'h1: begin
                    step <= 3'h2;
                    sh <= rg[7:0];
                  end
                  3'h2: begin
                    step <= rd ? 3'h4 : 3'h3;
                    sh <= wd;
                    if (rd) begin
                      state <= M_START;
                      step <= 3'h5;
                    end
                  end
                  3'h5: begin
                    rx_mode <= 1'b1;
                    step <= 3'h6;
                  end
                  default: begin
                    state <= M_STOP;
                  end
                endcase
              end
            end
          end
          M_STOP: begin
            // data rises while clock high
            if (phase == 2'h0) begin
              sda_low <= 1'b1;
            end else if (phase == 2'h1) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h2) begin
              sda_low <= 1'b0;
            end else begin
              state <= M_IDLE;
              cmd_ready <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_low;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_low;
endmodule : tws_master

// >>> verilog/tws_pkg.sv
// shared constants for the two-wire register slave and its master
package tws_pkg;
  // address byte layout
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // default and alternate seven-bit addresses (write byte 0x20 / 0x30)
  localparam logic [6:0] DEF_ADDR = 7'h10;
  localparam logic [6:0] ALT_ADDR = 7'h18;
  // programmable address register
  localparam logic [15:0] PROG_ADDR_OFFSET = 16'h31fc;
  localparam logic [15:0] PROG_ADDR_RESET = 16'h0000;
  // bit 8 of the programmable register enables its address in bits [7:1]
  localparam int PROG_EN_BIT = 8;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // master bus clock: core cycles per quarter of a bus clock period
  localparam int CORE_CLK_MHZ = 50;
  localparam int BUS_CLK_KHZ = 400;
  localparam int QUARTER_CYC = (CORE_CLK_MHZ * 1000) / (BUS_CLK_KHZ * 4);
  localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC - 1);
endpackage : tws_pkg

// >>> verilog/tws_slave.sv
// device end: two-wire register slave with 16-bit address pointer
`timescale 1ns/1ns
module tws_slave
  import tws_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  tws_bus_if.slave bus,
  input wire logic alt_address_enable,
  input wire logic alt_address_select,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire logic [7:0] reg_rdata,
  output logic [15:0] programmable_bus_address
);
  typedef enum {S_IDLE, S_ADDR, S_ACK, S_PTR_HI, S_PTR_LO, S_WDATA, S_RDATA, S_RACK}
    tws_state_e;
  tws_state_e state;
  tws_state_e after_ack;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_now;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [15:0] ptr;
  logic drive_low;
  logic [7:0] rd_byte;
  logic ack_go;
  logic rd_fetch;

  tws_line_watch u_watch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .scl(bus.scl),
    .sda(bus.bus_data_line),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_now(sda_now)
  );

  // ==========================================================
  // address matching
  wire [7:0] rx_byte = shreg;
  wire [6:0] rx_addr = rx_byte[ADDR_MSB:ADDR_LSB];
  wire rx_dir = rx_byte[DIR_BIT];
  wire [6:0] pin_addr = (alt_address_enable & alt_address_select) ? ALT_ADDR : DEF_ADDR;
  wire prog_en = programmable_bus_address[PROG_EN_BIT];
  wire [6:0] prog_addr = programmable_bus_address[ADDR_MSB:ADDR_LSB];
  wire addr_hit = (rx_addr == pin_addr) | (prog_en & (rx_addr == prog_addr));
  wire byte_done = scl_rise & (bit_cnt == BITS_PER_BYTE - 4'h1);
  wire [7:0] next_shreg = {shreg[6:0], sda_now};
  wire [15:0] next_ptr = ptr + 16'h0001;
  // register high byte at its offset, low byte at the next address
  wire prog_hit_hi = (ptr == PROG_ADDR_OFFSET);
  wire prog_hit_lo = (ptr == PROG_ADDR_OFFSET + 16'h0001);

  // ==========================================================
  // receive side and state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      after_ack <= S_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      ptr <= PTR_RESET;
      ack_go <= 1'b0;
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      reg_wdata <= 8'h00;
      programmable_bus_address <= PROG_ADDR_RESET;
    end else begin
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      // advance once the write strobe has shown the address
      if (reg_we) begin
        ptr <= next_ptr;
      end
      if (start_seen) begin
        state <= S_ADDR;
        bit_cnt <= 4'h0;
      end else if (stop_seen) begin
        state <= S_IDLE;
      end else begin
        unique case (state)
          S_IDLE: begin
          end
          S_ADDR, S_PTR_HI, S_PTR_LO, S_WDATA: begin
            if (scl_rise) begin
              shreg <= next_shreg;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
              ack_go <= 1'b1;
            end
            if (ack_go && scl_fall) begin
              ack_go <= 1'b0;
              bit_cnt <= 4'h0;
              unique case (state)
                S_ADDR: begin
                  if (addr_hit) begin
                    state <= S_ACK;
                    after_ack <= (rx_dir == DIR_READ) ? S_RDATA : S_PTR_HI;
                    reg_re <= (rx_dir == DIR_READ);
                  end else begin
                    state <= S_IDLE;
                  end
                end
                S_PTR_HI: begin
                  ptr[15:8] <= rx_byte;
                  state <= S_ACK;
                  after_ack <= S_PTR_LO;
                end
                S_PTR_LO: begin
                  ptr[7:0] <= rx_byte;
                  state <= S_ACK;
                  after_ack <= S_WDATA;
                end
                default: begin
                  reg_wdata <= rx_byte;
                  reg_we <= 1'b1;
                  if (prog_hit_hi) begin
                    programmable_bus_address[15:8] <= rx_byte;
                  end
                  if (prog_hit_lo) begin
                    programmable_bus_address[7:0] <= rx_byte;
                  end
                  state <= S_ACK;
                  after_ack <= S_WDATA;
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              state <= after_ack;
            end
          end
          S_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
              ack_go <= 1'b1;
            end
            if (ack_go && scl_fall) begin
              ack_go <= 1'b0;
              bit_cnt <= 4'h0;
              ptr <= next_ptr;
              state <= S_RACK;
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              shreg <= {7'h00, sda_now};
            end
            if (scl_fall) begin
              if (shreg[0] == 1'b0) begin
                state <= S_RDATA;
                reg_re <= 1'b1;
              end else begin
                state <= S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // data line driver
  assign reg_addr = ptr;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_byte <= 8'h00;
      rd_fetch <= 1'b0;
    end else begin
      // read data arrives the cycle after the request
      rd_fetch <= reg_re;
      if (rd_fetch) begin
        rd_byte <= reg_rdata;
      end
    end
  end
  // pick the level for the next low clock phase
  wire [2:0] rd_idx = 3'(7 - bit_cnt[2:0]);
  // hold the line released until fresh read data is in
  wire rd_busy = reg_re | rd_fetch;
  wire rd_level = (state == S_RDATA) & ~ack_go & ~rd_busy & ~rd_byte[rd_idx];
  wire ack_level = (state == S_ACK);
  wire next_drive_low = rd_level | ack_level;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drive_low <= 1'b0;
    end else if (start_seen | stop_seen) begin
      drive_low <= 1'b0;
    end else if (~bus.scl) begin
      drive_low <= next_drive_low;
    end
  end
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = drive_low;
endmodule : tws_slave
